// >>> hdl/timer_regs.svh
// Register indices, byte addresses, reset values and timing counts of the prescaled down timer.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Printed register indices; the bus byte address is four times the index.
`define PSC_IDX 8'hD2
`define CNT_IDX 8'hD3
`define CTRL_IDX 8'hD4
`define PSC_ADDR {2'h0, `PSC_IDX, 2'h0}
`define CNT_ADDR {2'h0, `CNT_IDX, 2'h0}
`define CTRL_ADDR {2'h0, `CTRL_IDX, 2'h0}

// Reset and reload values.
`define PSC_RELOAD 7'h7F
`define CNT_RELOAD 8'hFF
`define CTRL_RESET 8'h00

// Internal clock cycles per prescaler tick, and the last divider state.
`define INT_DIV 4'hC
`define INT_DIV_LAST 4'hB

// AXI4-Lite response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/timer_pkg.sv
// Types shared by the prescaled down timer files.
package timer_pkg;

    typedef logic [6:0] psc_t;
    typedef logic [7:0] cnt_t;
    typedef logic [1:0] resp_t;

    // Layout of the control and status register, bit 7 first.
    typedef struct packed {
        logic zero_flag;
        logic zero_irq_enable;
        logic rsv5;
        logic rsv4;
        logic prescaler_run;
        logic [2:0] tap_select;
    } ctrl_t;

    // Write channel progress of the register slave.
    typedef enum logic [1:0] {
        WR_COLLECT,
        WR_RESPOND
    } wr_state_t;

endpackage

// >>> hdl/tick_if.sv
// Carrier between the tick divider and the timer core.
`timescale 1ns/1ps
interface tick_if;
    logic enable;
    logic tick;

    modport gen (
        input enable,
        output tick
    );

    modport use_side (
        output enable,
        input tick
    );
endinterface

// >>> hdl/div12_tick.sv
// Divide-by-twelve enable pulse generator feeding the prescaler.
`timescale 1ns/1ps
`include "timer_regs.svh"
module div12_tick (
    input wire logic clk_i,
    input wire logic resetn_i,
    tick_if.gen tk
);

    logic [3:0] div_ff;
    logic [3:0] nxt_div;
    logic tick_ff;
    logic nxt_tick;

    // The divider pauses while disabled so a frozen timer resumes mid-period.
    always_comb begin
        nxt_div = div_ff;
        nxt_tick = 1'b0;
        if (tk.enable) begin
            if (div_ff == `INT_DIV_LAST) begin
                nxt_div = 4'h0;
                nxt_tick = 1'b1; // RULE21
            end else begin
                nxt_div = div_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_ff <= 4'h0;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tk.tick = tick_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_tick_spacing: assert property ( // RULE1
        tick_ff |=> !tick_ff [*8] ##1 !tick_ff [*3])
        else $error("Prescaler ticks closer than twelve cycles.");

endmodule

// >>> hdl/prescaled_down_timer.sv
// Eight-bit down timer with a seven-bit prescaler behind an AXI4-Lite register slave.
// Functional notes
// RULE1: Prescaler input tick is the internal clock divided by twelve.
// RULE2: Prescaler reloads 7Fh after reaching zero and keeps counting.
// RULE3: Counter decrements once per counter clock from the selected tap.
// RULE4: Counter reloads 0FFh after zero, counting freely.
// RULE5: Tap select picks one of eight taps, divide by two to the n.
// RULE6: Run bit clear holds counter and forces prescaler to 7Fh.
// RULE7: Reset sets counter to 0FFh and prescaler to 7Fh.
// RULE8: Prescaler register write loads prescaler directly while running.
// RULE9: Prescaler state is readable at any time.
// RULE10: Counter can be read and written while running.
// RULE11: Zero flag sets when the counter decrements to zero.
// RULE12: Interrupt request while zero flag and its enable are set.
// RULE13: Writing 00h to count or one to flag bit sets zero flag.
// RULE14: Software clears the zero flag; hardware never does.
// RULE15: Count write beats a simultaneous decrement to zero; no flag then.
// RULE16: Timer runs in wait mode; its interrupt wakes the device.
// RULE17: Stop mode freezes all timer registers and counting; bus writes to the prescaler, counter and control still land during stop.
// RULE18: Chain gives fifteen bits of range: 7-bit prescaler, 8-bit counter.
// RULE19: Tap codes 0 to 7 divide by 1, 2, 4 up to 128.
// RULE20: Control bits: flag 7, enable 6, run 3, tap 2..0, reset zero.
// RULE21: Divide-by-twelve tick is a one-cycle enable, not a clock.
// RULE22: Counter clock is a one-cycle enable at the tap pattern.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "timer_regs.svh"
module prescaled_down_timer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    output logic irq_o,
    output logic wake_o,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    tick_if tk ();

    timer_pkg::psc_t psc_ff;
    timer_pkg::psc_t nxt_psc;
    timer_pkg::cnt_t cnt_ff;
    timer_pkg::cnt_t nxt_cnt;
    timer_pkg::ctrl_t ctrl_ff;
    timer_pkg::ctrl_t nxt_ctrl;
    timer_pkg::ctrl_t wr_ctrl;

    timer_pkg::wr_state_t wr_state_ff;
    timer_pkg::wr_state_t nxt_wr_state;
    logic aw_hold_ff;
    logic nxt_aw_hold;
    logic w_hold_ff;
    logic nxt_w_hold;
    logic [11:0] awaddr_ff;
    logic [11:0] nxt_awaddr;
    logic [7:0] wbyte_ff;
    logic [7:0] nxt_wbyte;
    logic wlane_ff;
    logic nxt_wlane;
    timer_pkg::resp_t bresp_ff;
    timer_pkg::resp_t nxt_bresp;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    timer_pkg::resp_t rresp_ff;
    timer_pkg::resp_t nxt_rresp;

    logic wr_go;
    logic hit_psc;
    logic hit_cnt;
    logic hit_ctrl;
    logic psc_wr;
    logic cnt_wr;
    logic ctrl_wr;
    logic tick_act;
    logic cnt_en;
    logic hw_zero;
    logic [6:0] tap_mask;

    // Stop mode halts the divider itself, so nothing can count while frozen.
    assign tk.enable = !stop_mode_i; // RULE17

    div12_tick u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tk(tk)
    );

    // Tap mask: bit i is set when the selected tap lies above bit i.
    generate
        for (genvar i = 0; i < 7; i++) begin : g_mask
            assign tap_mask[i] = (ctrl_ff.tap_select > 3'(i)); // RULE5 RULE19
        end
    endgenerate

    // The counter steps when the masked low prescaler bits are all zero, once every 2^n ticks.
    assign tick_act = tk.tick && ctrl_ff.prescaler_run && !stop_mode_i; // RULE6 RULE17
    assign cnt_en = tick_act && ((psc_ff & tap_mask) == 7'h00); // RULE3 RULE22 RULE18
    assign hw_zero = cnt_en && (cnt_ff == 8'h01) && !cnt_wr; // RULE11 RULE15

    // Write side decode, applied only when both address and data are in hand.
    assign wr_go = (wr_state_ff == timer_pkg::WR_COLLECT) && aw_hold_ff && w_hold_ff;
    assign hit_psc = (awaddr_ff == `PSC_ADDR);
    assign hit_cnt = (awaddr_ff == `CNT_ADDR);
    assign hit_ctrl = (awaddr_ff == `CTRL_ADDR);
    assign psc_wr = wr_go && wlane_ff && hit_psc && ctrl_ff.prescaler_run; // RULE8
    assign cnt_wr = wr_go && wlane_ff && hit_cnt; // RULE10
    assign ctrl_wr = wr_go && wlane_ff && hit_ctrl;
    assign wr_ctrl = timer_pkg::ctrl_t'(wbyte_ff);

    // Prescaler, counter and control next values.
    always_comb begin
        nxt_psc = psc_ff;
        nxt_cnt = cnt_ff;
        nxt_ctrl = ctrl_ff;
        if (!ctrl_ff.prescaler_run) begin
            nxt_psc = `PSC_RELOAD; // RULE6
        end else if (psc_wr) begin
            nxt_psc = wbyte_ff[6:0]; // RULE8
        end else if (tick_act) begin
            if (psc_ff == 7'h00) begin
                nxt_psc = `PSC_RELOAD; // RULE2
            end else begin
                nxt_psc = psc_ff - 7'h01; // RULE1
            end
        end
        if (cnt_wr) begin
            nxt_cnt = wbyte_ff; // RULE10 RULE15
        end else if (cnt_en) begin
            if (cnt_ff == 8'h00) begin
                nxt_cnt = `CNT_RELOAD; // RULE4
            end else begin
                nxt_cnt = cnt_ff - 8'h01; // RULE3
            end
        end
        if (ctrl_wr) begin
            nxt_ctrl = wr_ctrl; // RULE20 RULE14
        end
        // Any set wins over a software clear landing in the same cycle.
        if (hw_zero || (cnt_wr && (wbyte_ff == 8'h00))) begin
            nxt_ctrl.zero_flag = 1'b1; // RULE11 RULE13
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psc_ff <= `PSC_RELOAD; // RULE7
            cnt_ff <= `CNT_RELOAD; // RULE7
            ctrl_ff <= `CTRL_RESET; // RULE20
        end else begin
            psc_ff <= nxt_psc;
            cnt_ff <= nxt_cnt;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Request and wake are plain gates on flops; wake only counts in wait mode.
    assign irq_o = ctrl_ff.zero_flag && ctrl_ff.zero_irq_enable; // RULE12
    assign wake_o = irq_o && wait_mode_i; // RULE16

    // Write channel: address and data are taken in either order, then answered.
    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wbyte = wbyte_ff;
        nxt_wlane = wlane_ff;
        nxt_bresp = bresp_ff;
        case (wr_state_ff)
            timer_pkg::WR_COLLECT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    nxt_aw_hold = 1'b1;
                    nxt_awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    nxt_w_hold = 1'b1;
                    nxt_wbyte = s_axi_wdata[7:0];
                    nxt_wlane = s_axi_wstrb[0];
                end
                if (wr_go) begin
                    nxt_aw_hold = 1'b0;
                    nxt_w_hold = 1'b0;
                    nxt_wr_state = timer_pkg::WR_RESPOND;
                    if (hit_psc || hit_cnt || hit_ctrl) begin
                        nxt_bresp = `RESP_OKAY;
                    end else begin
                        nxt_bresp = `RESP_SLVERR;
                    end
                end
            end
            timer_pkg::WR_RESPOND: begin
                if (s_axi_bready) begin
                    nxt_wr_state = timer_pkg::WR_COLLECT;
                end
            end
            default: begin
                nxt_wr_state = timer_pkg::WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_state_ff <= timer_pkg::WR_COLLECT;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awaddr_ff <= nxt_awaddr;
            wbyte_ff <= nxt_wbyte;
            wlane_ff <= nxt_wlane;
            bresp_ff <= nxt_bresp;
        end
    end

    // Ready drops while a word is held, which back-pressures a second write.
    assign s_axi_awready = (wr_state_ff == timer_pkg::WR_COLLECT) && !aw_hold_ff;
    assign s_axi_wready = (wr_state_ff == timer_pkg::WR_COLLECT) && !w_hold_ff;
    assign s_axi_bvalid = (wr_state_ff == timer_pkg::WR_RESPOND);
    assign s_axi_bresp = bresp_ff;

    // Read channel: the answer is registered one cycle after the address is taken.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `RESP_OKAY;
            if (s_axi_araddr == `PSC_ADDR) begin
                nxt_rdata = {25'h0000000, psc_ff}; // RULE9
            end else if (s_axi_araddr == `CNT_ADDR) begin
                nxt_rdata = {24'h000000, cnt_ff}; // RULE10
            end else if (s_axi_araddr == `CTRL_ADDR) begin
                nxt_rdata = {24'h000000, ctrl_ff};
            end else begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_write_commit;
        wr_go;
    endsequence

    // The answer is a single flop step behind the commit, so no range is needed here.
    sequence s_write_answer;
        s_axi_bvalid;
    endsequence

    sequence s_answer_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    a_psc_reload: assert property ( // RULE2
        tick_act && (psc_ff == 7'h00) && !psc_wr |=> psc_ff == `PSC_RELOAD)
        else $error("Prescaler did not reload after zero.");

    a_cnt_step: assert property ( // RULE3
        cnt_en && (cnt_ff != 8'h00) && !cnt_wr |=> cnt_ff == $past(cnt_ff) - 8'h01)
        else $error("Counter did not step down on its tap enable.");

    a_cnt_reload: assert property ( // RULE4
        cnt_en && (cnt_ff == 8'h00) && !cnt_wr |=> cnt_ff == `CNT_RELOAD)
        else $error("Counter did not reload after zero.");

    a_tap_rate: assert property ( // RULE5
        cnt_en |-> tick_act && ((psc_ff & ~(7'h7F << ctrl_ff.tap_select)) == 7'h00))
        else $error("Counter enable fired off its selected tap.");

    a_idle_hold: assert property ( // RULE6
        !ctrl_ff.prescaler_run && !cnt_wr |=> psc_ff == `PSC_RELOAD && $stable(cnt_ff))
        else $error("Stopped timer did not hold its counter or preset its prescaler.");

    a_flag_on_zero: assert property ( // RULE11
        hw_zero |=> ctrl_ff.zero_flag && cnt_ff == 8'h00)
        else $error("Zero flag missing after decrement to zero.");

    a_irq_level: assert property ( // RULE12
        hw_zero && ctrl_ff.zero_irq_enable && !ctrl_wr |=> irq_o)
        else $error("Interrupt request missing after an enabled underflow.");

    a_write_zero: assert property ( // RULE13
        cnt_wr && (wbyte_ff == 8'h00) |=> ctrl_ff.zero_flag)
        else $error("Writing zero to the count did not raise the flag.");

    a_write_wins: assert property ( // RULE15
        cnt_wr && cnt_en && (cnt_ff == 8'h01) && (wbyte_ff != 8'h00) && !ctrl_ff.zero_flag
        |=> cnt_ff == $past(wbyte_ff) && !ctrl_ff.zero_flag)
        else $error("Count write lost to a decrement or raised the flag.");

    a_stop_freeze: assert property ( // RULE17
        stop_mode_i && !wr_go |=> $stable(psc_ff) && $stable(cnt_ff))
        else $error("Timer moved during stop mode.");

    a_bus_answer: assert property (
        s_write_commit |=> s_write_answer)
        else $error("Write response missing after commit.");

    a_bus_hold: assert property (
        s_answer_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was accepted.");

endmodule

// >>> test/tb_top.sv
// Self-checking bench for the prescaled down timer, driven over its register bus.
`timescale 1ns/1ps
`include "timer_regs.svh"
module tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic irq_o;
    logic wake_o;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int n_errors = 0;
    int checks = 0;

    prescaled_down_timer dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wake_o(wake_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    // A 125 MHz clock.
    always #4 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic miss(input string m);
        n_errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            miss($sformatf("%s: got %h, wanted %h", m, got, exp));
        end
    endtask

    // Ready is sampled at the falling edge, where it is settled and equals its value at the
    // next rising edge, so the handshake is judged without racing the design's flops.
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ah;
        logic wh;
        logic bv;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk_i);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (ah) begin
                s_axi_awvalid <= 1'b0;
            end
            if (wh) begin
                s_axi_wvalid <= 1'b0;
            end
            if (bv) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        miss("write got no answer");
        close_out();
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah;
        logic rv;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk_i);
            ah = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ah) begin
                s_axi_arvalid <= 1'b0;
            end
            if (rv) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        miss("read got no answer");
        close_out();
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        bus_wr(a, d, r);
        check_eq({30'h0, r}, {30'h0, `RESP_OKAY}, "write response");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string m);
        logic [31:0] d;
        logic [1:0] r;
        bus_rd(a, d, r);
        check_eq(d, exp, m);
    endtask

    // Counts cycles until the interrupt request shows; a missing one ends the run.
    task automatic wait_irq(input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(negedge clk_i);
            if (irq_o === 1'b1) begin
                return;
            end
        end
        miss("interrupt never came");
        close_out();
    endtask

    // With the run bit clear nothing moves and a prescaler write is ignored.
    task automatic t_reset_hold();
        rd_chk(`PSC_ADDR, 32'h0000007F, "prescaler after reset");
        rd_chk(`CNT_ADDR, 32'h000000FF, "count after reset");
        rd_chk(`CTRL_ADDR, 32'h00000000, "control after reset");
        wr(`PSC_ADDR, 8'h10);
        repeat (200) @(posedge clk_i);
        rd_chk(`PSC_ADDR, 32'h0000007F, "prescaler while stopped");
        rd_chk(`CNT_ADDR, 32'h000000FF, "count while stopped");
    endtask

    // Every tap: three counts to underflow take between two and three counter periods.
    task automatic t_taps();
        int n;
        int p;
        for (int tap = 0; tap < 8; tap++) begin
            p = 12 * (1 << tap);
            wr(`CTRL_ADDR, 8'h48 | 8'(tap));
            wr(`CNT_ADDR, 8'h03);
            wait_irq(3 * p + 60, n);
            check_eq(32'(n >= 2 * p - 4 && n <= 3 * p + 4), 32'h1, "underflow timing");
            rd_chk(`CTRL_ADDR, 32'h000000C8 | 32'(tap), "flag after underflow");
        end
    endtask

    // Direct prescaler loads drive the slowest tap to its step, reload and wrap.
    task automatic t_reload();
        int n;
        wr(`CTRL_ADDR, 8'h4F);
        wr(`CNT_ADDR, 8'h01);
        wr(`PSC_ADDR, 8'h02);
        wait_irq(80, n);
        check_eq(32'(n <= 40), 32'h1, "step after prescaler load");
        rd_chk(`PSC_ADDR, 32'h0000007F, "prescaler reload");
        rd_chk(`CNT_ADDR, 32'h00000000, "count at zero");
        wr(`CTRL_ADDR, 8'h4F);
        wr(`PSC_ADDR, 8'h01);
        repeat (40) @(posedge clk_i);
        rd_chk(`CNT_ADDR, 32'h000000FF, "count wraps");
        rd_chk(`CTRL_ADDR, 32'h0000004F, "no flag on wrap");
    endtask

    // Software sets of the flag, interrupt gating, wake, strobe and reserved bits.
    task automatic t_flag_writes();
        wr(`CTRL_ADDR, 8'h08);
        wr(`CNT_ADDR, 8'h00);
        rd_chk(`CTRL_ADDR, 32'h00000088, "flag by count write");
        check_eq({31'h0, irq_o}, 32'h0, "request while disabled");
        wr(`CTRL_ADDR, 8'h48);
        check_eq({31'h0, irq_o}, 32'h0, "request after clear");
        wr(`CTRL_ADDR, 8'hC8);
        check_eq({31'h0, irq_o}, 32'h1, "request with flag and enable");
        check_eq({31'h0, wake_o}, 32'h0, "wake outside wait");
        @(posedge clk_i);
        wait_mode_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        @(negedge clk_i);
        check_eq({31'h0, irq_o}, 32'h1, "flag kept by hardware");
        check_eq({31'h0, wake_o}, 32'h1, "wake in wait");
        @(posedge clk_i);
        wait_mode_i <= 1'b0;
        s_axi_wstrb <= 4'h0;
        wr(`CTRL_ADDR, 8'h00);
        s_axi_wstrb <= 4'hF;
        rd_chk(`CTRL_ADDR, 32'h000000C8, "masked write ignored");
        wr(`CTRL_ADDR, 8'h30);
        rd_chk(`CTRL_ADDR, 32'h00000030, "reserved bits kept");
        check_eq({31'h0, irq_o}, 32'h0, "request after clear");
    endtask

    // Stop freezes both stages; release lets them move again; unmapped access errs.
    task automatic t_stop_unmapped();
        logic [31:0] c0;
        logic [31:0] p0;
        logic [31:0] d;
        logic [1:0] r;
        // The slowest tap keeps the count still while it is read back; tap 0 then moves it.
        wr(`CTRL_ADDR, 8'h4F);
        wr(`CNT_ADDR, 8'h80);
        rd_chk(`CNT_ADDR, 32'h00000080, "count write on the fly");
        wr(`CTRL_ADDR, 8'h48);
        @(posedge clk_i);
        stop_mode_i <= 1'b1;
        bus_rd(`CNT_ADDR, c0, r);
        bus_rd(`PSC_ADDR, p0, r);
        repeat (100) @(posedge clk_i);
        rd_chk(`CNT_ADDR, c0, "count frozen in stop");
        rd_chk(`PSC_ADDR, p0, "prescaler frozen in stop");
        @(posedge clk_i);
        stop_mode_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        bus_rd(`PSC_ADDR, d, r);
        check_eq(32'(d != p0), 32'h1, "prescaler moves again");
        bus_rd(`CNT_ADDR, d, r);
        check_eq(32'(d != c0), 32'h1, "count moves again");
        bus_wr(12'h354, 8'h55, r);
        check_eq({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
        bus_rd(12'h354, d, r);
        check_eq({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped read");
        check_eq(d, 32'h00000000, "unmapped read data");
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset_hold();
        t_taps();
        t_reload();
        t_flag_writes();
        t_stop_unmapped();
        close_out();
    end
endmodule
